// *** pswitch_pkg.sv ***
package pswitch_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_OPERATION = 8'h00;
  localparam logic [7:0] OFS_PULSE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_VIN = 8'h0c;
  localparam logic [7:0] OFS_VOUT = 8'h10;
  localparam logic [7:0] OFS_ADDRESS = 8'h14;
  // Field positions
  localparam int OP_ON_BIT = 7;
  localparam int PULSE_EN_BIT = 0;
  localparam int PULSE_ON_LSB = 8;
  localparam int PULSE_OFF_LSB = 16;
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_UV_BIT = 1;
  localparam int ST_OV_BIT = 2;
  localparam int ST_POWER_GOOD_BIT = 3;
  localparam int ST_ADDR_DEF_BIT = 4;
  // Reset values
  localparam logic [7:0] OPERATION_RESET = 8'h80;
  localparam logic [23:0] PULSE_RESET = 24'h000000;
  // Fault timer: charge is twenty times faster than discharge
  localparam logic [15:0] CHARGE_STEP = 16'h0014;
  localparam logic [15:0] DISCHARGE_STEP = 16'h0001;
  localparam logic [15:0] FAULT_TIMEOUT_DEFAULT = 16'h0400;
  localparam logic [7:0] OSC_DIV_MIN = 8'h01;
  // Bus address used when the strapped one is unusable
  localparam logic [6:0] DEFAULT_ADDRESS = 7'h61;
  localparam logic [6:0] RESERVED_LOW_MAX = 7'h07;
  localparam logic [6:0] RESERVED_HIGH_MIN = 7'h78;
  // Serial receiver states
  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_ACK, SER_HOLD} ser_state_t;
endpackage : pswitch_pkg

// *** pin_sync.sv ***
// Two flip-flop synchroniser for a group of independent levels
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync

// *** power_switch_ctrl.sv ***
// How it works
// - Inrush gate needs its enable high, master enable low, ON bit 7 set.
// - ORing gate needs its enable high, master enable low, ON bit 7 set.
// - Pulse timing from bus when enabled, else master enable pin paces it.
// - Master reset low forces both gates off strongly, clears fault timer, flags and control registers, and retakes the address.
// - Sleep low turns both gates off and enters low-power mode.
// - Sleep high or floating gives normal fault-driven gate control.
// - Bus enable low blocks every management function; high enables it.
// - Power good only while supplies, input and feedback are in range.
// - Low feedback drops power good but leaves the load gate alone.
// - Current-limit output goes low while a current fault is present.
// - Undervoltage lockout turns the load gate off.
// - Overvoltage lockout turns the load gate off.
// - Overcurrent starts the fault timer; capacitor or default sets timeout.
// - Timers tick from an oscillator whose rate the timer capacitor sets.
// - Input and load voltage readings are visible only via management bus.
// - Open-drain alert output signals faults to the host.
// - Serial port: open-drain data line plus host-driven clock input.
// - Strapped ternary address checked by odd parity; else default address.
// - Timer charges over limit, discharges below, twenty to one, hiccup.
//
// Chosen here: strobed register access and the address map.
module power_switch_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Enable and mode pins
  input wire logic inrush_gate_enable,
  input wire logic or_gate_enable,
  input wire logic master_enable_n,
  input wire logic master_reset_n,
  input wire logic sleep_n,
  input wire logic mgmt_bus_enable,
  // Comparators and analog status
  input wire logic undervoltage_lockout,
  input wire logic overvoltage_lockout,
  input wire logic feedback_low,
  input wire logic supply_ok,
  input wire logic current_monitor,
  input wire logic fault_cap_fitted,
  input wire logic [11:0] fault_cap_timeout,
  input wire logic [7:0] timer_cap_div,
  // Converter results, same clock
  input wire logic [9:0] adc_vin,
  input wire logic [9:0] adc_vout,
  // Address straps, two bits per ternary digit
  input wire logic [9:0] address_strap,
  input wire logic address_parity,
  // Serial management link
  input wire logic serial_clock_side1,
  input wire logic serial_data_side1_in,
  output logic serial_data_side1_out,
  output logic serial_data_side1_oe,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Gate drive and status pins
  output logic inrush_gate_on,
  output logic or_gate_on,
  output logic gate_strong_off,
  output logic low_power,
  output logic power_good_oe,
  output logic current_limit_fault_n_oe,
  output logic alert_n_oe
);
  import pswitch_pkg::*;

  localparam int SYNC_W = 45;
  logic [SYNC_W-1:0] sync_q;
  logic inr_en, or_en, men_n, mrst_n, slp_n, bus_en, uv, ov, fb_low, sup_ok;
  logic over_cur, cap_fit, par, scl, sda;
  logic [11:0] cap_to;
  logic [7:0] osc_div;
  logic [9:0] strap;

  // All pins except the converter results and the register port cross into clk_sys before any logic reads them
  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in({inrush_gate_enable, or_gate_enable, master_enable_n, master_reset_n,
               sleep_n, mgmt_bus_enable, undervoltage_lockout, overvoltage_lockout,
               feedback_low, supply_ok, current_monitor, fault_cap_fitted,
               address_parity, serial_clock_side1, serial_data_side1_in,
               fault_cap_timeout, timer_cap_div, address_strap}),
    .sync_out(sync_q)
  );
  assign {inr_en, or_en, men_n, mrst_n, slp_n, bus_en, uv, ov, fb_low, sup_ok,
          over_cur, cap_fit, par, scl, sda, cap_to, osc_div, strap} = sync_q;

  logic [7:0] operation;
  logic [23:0] pulse_cfg;
  logic [2:0] sticky;
  logic [6:0] bus_address;
  logic addr_taken, addr_default;
  logic tick;
  logic [7:0] div_cnt;
  logic [15:0] fault_cnt;
  logic tripped;
  logic pulse_phase;
  logic [7:0] pulse_cnt;

  // Timer oscillator: one-cycle tick every osc_div cycles
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (div_cnt + OSC_DIV_MIN >= osc_div) begin
      div_cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // Effective timeout: capacitor-set when fitted, internal default otherwise
  logic [15:0] timeout;
  assign timeout = cap_fit ? {4'h0, cap_to} : FAULT_TIMEOUT_DEFAULT;

  // Hiccup fault timer; trip holds until fully discharged, then retry
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fault_cnt <= 16'h0000;
      tripped <= 1'b0;
    end else if (!mrst_n) begin
      fault_cnt <= 16'h0000;
      tripped <= 1'b0;
    end else if (tick) begin
      if (over_cur) begin
        fault_cnt <= (fault_cnt > 16'hffff - CHARGE_STEP) ? 16'hffff : fault_cnt + CHARGE_STEP;
        if (fault_cnt + CHARGE_STEP >= timeout) begin
          tripped <= 1'b1;
        end
      end else if (fault_cnt >= DISCHARGE_STEP) begin
        fault_cnt <= fault_cnt - DISCHARGE_STEP;
        if (fault_cnt == DISCHARGE_STEP) begin
          tripped <= 1'b0;
        end
      end else begin
        tripped <= 1'b0;
      end
    end
  end

  // Pulse mode paced by bus timing; without the bus the enable pin paces it
  logic pulse_mode;
  assign pulse_mode = bus_en && pulse_cfg[PULSE_EN_BIT];
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pulse_phase <= 1'b1;
      pulse_cnt <= 8'h00;
    end else if (!mrst_n || !pulse_mode) begin
      pulse_phase <= 1'b1;
      pulse_cnt <= 8'h00;
    end else if (tick) begin
      if (pulse_cnt >= (pulse_phase ? pulse_cfg[PULSE_ON_LSB +: 8]
                                    : pulse_cfg[PULSE_OFF_LSB +: 8])) begin
        pulse_phase <= !pulse_phase;
        pulse_cnt <= 8'h00;
      end else begin
        pulse_cnt <= pulse_cnt + 8'h01;
      end
    end
  end

  // Gate permission; bus-blocked means the ON bit cannot hold gates off
  logic on_eff, common_ok, next_inrush, next_or, pg_cond;
  assign on_eff = bus_en ? operation[OP_ON_BIT] : 1'b1;
  assign common_ok = mrst_n && slp_n && !men_n && on_eff && pulse_phase;
  assign next_inrush = common_ok && inr_en && !uv && !ov && !tripped;
  assign next_or = common_ok && or_en && !tripped;
  assign pg_cond = sup_ok && !uv && !ov && !fb_low;

  // Gate drivers and status pins, all registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      inrush_gate_on <= 1'b0;
      or_gate_on <= 1'b0;
      gate_strong_off <= 1'b1;
      low_power <= 1'b0;
      power_good_oe <= 1'b1;
      current_limit_fault_n_oe <= 1'b0;
    end else begin
      inrush_gate_on <= next_inrush;
      or_gate_on <= next_or;
      gate_strong_off <= !mrst_n;
      low_power <= !slp_n;
      power_good_oe <= !pg_cond;
      current_limit_fault_n_oe <= tripped;
    end
  end

  // Sticky fault flags for software; a new event beats a clear
  logic [2:0] events;
  assign events = {ov, uv, tripped};
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sticky <= 3'h0;
    end else if (!mrst_n) begin
      sticky <= 3'h0;
    end else if (reg_write && bus_en && reg_addr == OFS_STATUS) begin
      sticky <= (sticky & ~reg_wdata[2:0]) | events;
    end else begin
      sticky <= sticky | events;
    end
  end

  // Alert drives low while any flag stands and the bus is live
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alert_n_oe <= 1'b0;
    end else begin
      alert_n_oe <= bus_en && slp_n && (sticky != 3'h0);
    end
  end

  // Ternary strap decode: 00 ground, 01 floating, 10 supply
  function automatic logic [7:0] tern_value(input logic [9:0] s);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 4; i >= 0; i--) begin
      v = 8'(v * 8'h03 + (s[2*i +: 2] == 2'b10 ? 8'h02 : (s[2*i +: 2] == 2'b00 ? 8'h00 : 8'h01)));
    end
    return v;
  endfunction : tern_value

  // Address taken once after reset release, checked by odd parity
  logic [7:0] tval;
  logic par_ok, reserved;
  assign tval = tern_value(strap);
  assign par_ok = ^{tval, par};
  assign reserved = tval[7] || tval[6:0] <= RESERVED_LOW_MAX || tval[6:0] >= RESERVED_HIGH_MIN;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addr_taken <= 1'b0;
      addr_default <= 1'b1;
      bus_address <= DEFAULT_ADDRESS;
    end else if (!mrst_n) begin
      addr_taken <= 1'b0;
    end else if (!addr_taken) begin
      addr_taken <= 1'b1;
      addr_default <= !par_ok || reserved;
      bus_address <= (!par_ok || reserved) ? DEFAULT_ADDRESS : tval[6:0];
    end
  end

  // Control registers; writes ignored while the bus is disabled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      operation <= OPERATION_RESET;
      pulse_cfg <= PULSE_RESET;
    end else if (!mrst_n) begin
      operation <= OPERATION_RESET;
      pulse_cfg <= PULSE_RESET;
    end else if (reg_write && bus_en) begin
      if (reg_addr == OFS_OPERATION) begin
        operation <= reg_wdata[7:0];
      end else if (reg_addr == OFS_PULSE) begin
        pulse_cfg <= reg_wdata[23:0];
      end
    end
  end

  // Read data one cycle after the strobe; zero when blocked or unmapped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_read || !bus_en) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == OFS_OPERATION) begin
      reg_rdata <= {24'h000000, operation};
    end else if (reg_addr == OFS_PULSE) begin
      reg_rdata <= {8'h00, pulse_cfg};
    end else if (reg_addr == OFS_STATUS) begin
      reg_rdata <= {27'h0000000, addr_default, pg_cond, sticky};
    end else if (reg_addr == OFS_VIN) begin
      reg_rdata <= {22'h000000, adc_vin};
    end else if (reg_addr == OFS_VOUT) begin
      reg_rdata <= {22'h000000, adc_vout};
    end else if (reg_addr == OFS_ADDRESS) begin
      reg_rdata <= {25'h0000000, bus_address};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Serial link: find start/stop, shift the address, acknowledge a match
  ser_state_t ser_state;
  logic scl_d, sda_d;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic scl_rise, scl_fall, start_c, stop_c, ser_live;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_c = scl && scl_d && sda_d && !sda;
  assign stop_c = scl && scl_d && !sda_d && sda;
  assign ser_live = bus_en && slp_n && mrst_n;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // Data line is open drain: only ever pulled low
  assign serial_data_side1_out = 1'b0;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ser_state <= SER_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      serial_data_side1_oe <= 1'b0;
    end else if (!ser_live || stop_c) begin
      ser_state <= SER_IDLE;
      serial_data_side1_oe <= 1'b0;
    end else if (start_c) begin
      ser_state <= SER_SHIFT;
      bit_cnt <= 4'h0;
      serial_data_side1_oe <= 1'b0;
    end else begin
      case (ser_state)
        SER_SHIFT: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (shreg[7:1] == bus_address) begin
              ser_state <= SER_ACK;
              serial_data_side1_oe <= 1'b1;
            end else begin
              ser_state <= SER_IDLE;
            end
          end
        end
        SER_ACK: begin
          if (scl_fall) begin
            ser_state <= SER_HOLD;
            serial_data_side1_oe <= 1'b0;
          end
        end
        SER_HOLD: begin
          ser_state <= SER_HOLD;
        end
        default: begin
          ser_state <= SER_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  inrush_permit_a: assert property (inrush_gate_on |->
    $past(inr_en) && !$past(men_n) && $past(on_eff))
    else $error("inrush gate on without its enables");
  or_permit_a: assert property (or_gate_on |->
    $past(or_en) && !$past(men_n) && $past(on_eff))
    else $error("oring gate on without its enables");
  reset_forces_off_a: assert property (!mrst_n |=>
    gate_strong_off && !inrush_gate_on && !or_gate_on && !tripped && sticky == 3'h0)
    else $error("master reset did not force gates off");
  sleep_gates_off_a: assert property (!slp_n |=>
    low_power && !inrush_gate_on && !or_gate_on)
    else $error("sleep did not disable gates");
  bus_blocked_a: assert property (!bus_en && reg_read |=> reg_rdata == 32'h00000000)
    else $error("read answered while bus disabled");
  power_good_follow_a: assert property (pg_cond |=> !power_good_oe)
    else $error("power good held low while in range");
  // Antecedent leaves fb_low out of the gate terms, so gating the load on it would fire
  feedback_only_a: assert property (fb_low && common_ok && inr_en && !uv && !ov && !tripped
    |=> power_good_oe && inrush_gate_on)
    else $error("low feedback touched the load gate");
  curlim_flag_a: assert property (tripped |=> current_limit_fault_n_oe)
    else $error("current limit pin not driven on fault");
  uv_lockout_a: assert property (uv |=> !inrush_gate_on)
    else $error("load gate on during undervoltage");
  ov_lockout_a: assert property (ov |=> !inrush_gate_on)
    else $error("load gate on during overvoltage");
  hiccup_charge_a: assert property (mrst_n && tick && over_cur && fault_cnt < 16'h0100
    |=> fault_cnt == $past(fault_cnt) + CHARGE_STEP)
    else $error("fault timer charge step wrong");
  hiccup_drain_a: assert property (mrst_n && tick && !over_cur && fault_cnt != 16'h0000
    |=> fault_cnt == $past(fault_cnt) - DISCHARGE_STEP)
    else $error("fault timer discharge step wrong");
endmodule : power_switch_ctrl

// *** pswitch_host.sv ***
// Management host on the far side of the serial link
module pswitch_host (
  // Serial link
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock stands high between frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Sends START and one address byte, samples the acknowledge, then STOP
  task automatic send_addr(input logic [7:0] b, output logic ack);
    // Phase offset keeps link edges away from the system clock edges
    #7 sda_low = 1'b1;
    #80 scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #40 sda_low = ~b[i];
      #40 scl = 1'b1;
      #80 scl = 1'b0;
    end
    // Release data so only the block can pull it low
    #40 sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 ack = (sda === 1'b0);
    #40 scl = 1'b0;
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #80;
  endtask : send_addr
endmodule : pswitch_host

// *** tb_power_switch_ctrl.sv ***
module tb_power_switch_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import pswitch_pkg::*;

  // Pins, strobes and outputs
  logic clk_sys, rst_b, inrush_gate_enable, or_gate_enable, master_enable_n, master_reset_n;
  logic sleep_n, mgmt_bus_enable, undervoltage_lockout, overvoltage_lockout, feedback_low;
  logic supply_ok, current_monitor, fault_cap_fitted, address_parity, reg_write, reg_read;
  logic [11:0] fault_cap_timeout;
  logic [7:0] timer_cap_div, reg_addr;
  logic [9:0] adc_vin, adc_vout, address_strap;
  logic [31:0] reg_wdata, reg_rdata;
  logic serial_data_side1_out, serial_data_side1_oe, inrush_gate_on, or_gate_on;
  logic gate_strong_off, low_power, power_good_oe, current_limit_fault_n_oe, alert_n_oe;
  logic scl, sda_low, sda, ack;
  int failures, check_count;

  always #10 clk_sys = ~clk_sys;
  // Open-drain data line with its pull-up
  assign sda = !(sda_low | serial_data_side1_oe & !serial_data_side1_out);

  power_switch_ctrl dut (.clk_sys, .rst_b, .inrush_gate_enable, .or_gate_enable,
    .master_enable_n, .master_reset_n, .sleep_n, .mgmt_bus_enable, .undervoltage_lockout,
    .overvoltage_lockout, .feedback_low, .supply_ok, .current_monitor, .fault_cap_fitted,
    .fault_cap_timeout, .timer_cap_div, .adc_vin, .adc_vout, .address_strap, .address_parity,
    .serial_clock_side1(scl), .serial_data_side1_in(sda), .serial_data_side1_out,
    .serial_data_side1_oe, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .inrush_gate_on, .or_gate_on, .gate_strong_off, .low_power, .power_good_oe,
    .current_limit_fault_n_oe, .alert_n_oe);
  pswitch_host host (.scl, .sda_low, .sda);

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Pins pass two synchroniser stages and a register, so allow a margin
  task automatic settle;
    repeat (6) @(posedge clk_sys);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    chk(reg_rdata, exp, what);
  endtask : rd

  task automatic gates(input logic [1:0] e, input string what);
    chk(32'({inrush_gate_on, or_gate_on}), 32'(e), what);
  endtask : gates

  task automatic bus(input logic on);
    @(posedge clk_sys);
    mgmt_bus_enable <= on;
    settle();
  endtask : bus

  task automatic wfault(input logic lvl, input int bound, output int n);
    n = 0;
    while (current_limit_fault_n_oe !== lvl) begin
      @(posedge clk_sys);
      n++;
      if (n > bound) begin
        failures++;
        $display("CHECK FAILED at %0t: fault flag wait ran out", $time);
        conclude();
      end
    end
  endtask : wfault

  task automatic t_enables;
    logic [1:0] e;
    for (int i = 0; i < 16; i++) begin
      wr(OFS_OPERATION, 32'(i[3]) << OP_ON_BIT);
      @(posedge clk_sys);
      inrush_gate_enable <= i[0];
      or_gate_enable <= i[1];
      master_enable_n <= i[2];
      settle();
      e = {i[0], i[1]} & {2{i[3] & ~i[2]}};
      gates(e, "enable combination");
    end
    @(posedge clk_sys);
    master_enable_n <= 1'b0;
  endtask : t_enables

  // Bus off hides the ON bit and drops register writes
  task automatic t_bus_off;
    wr(OFS_OPERATION, 32'h0);
    settle();
    gates(2'b00, "commanded off");
    bus(1'b0);
    gates(2'b11, "ON ignored with bus off");
    wr(OFS_OPERATION, 32'h80);
    rd(OFS_OPERATION, 32'h0, "read with bus off");
    bus(1'b1);
    gates(2'b00, "write dropped with bus off");
    wr(OFS_OPERATION, 32'h80);
    settle();
  endtask : t_bus_off

  // Four ticks on, four off: a toggle every four cycles, every eight at half the tick rate
  task automatic t_pulse;
    int n;
    logic p;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      timer_cap_div <= (k == 1) ? 8'h02 : 8'h01;
      if (k == 0) wr(OFS_PULSE, 32'h0003_0301);
      else if (k == 1) settle();
      else bus(1'b0);
      n = 0;
      p = inrush_gate_on;
      repeat (80) begin
        @(posedge clk_sys);
        if (inrush_gate_on !== p) n++;
        p = inrush_gate_on;
      end
      if (k == 0) chk(32'(n >= 18 && n <= 21), 32'h1, "pulse toggles");
      else if (k == 1) chk(32'(n >= 9 && n <= 11), 32'h1, "pulse at half rate");
      else chk(32'(n), 32'h0, "pulse without bus");
    end
    bus(1'b1);
    wr(OFS_PULSE, 32'h0);
  endtask : t_pulse

  task automatic t_sleep;
    @(posedge clk_sys);
    sleep_n <= 1'b0;
    // Two edges in, the level is still inside the synchroniser
    repeat (2) @(posedge clk_sys);
    chk(32'(low_power), 32'h0, "sleep seen too soon");
    settle();
    chk(32'({low_power, inrush_gate_on, or_gate_on}), 32'h4, "sleep");
    @(posedge clk_sys);
    sleep_n <= 1'b1;
    settle();
    chk(32'({low_power, inrush_gate_on, or_gate_on}), 32'h3, "wake");
  endtask : t_sleep

  task automatic t_power_good;
    chk(32'(power_good_oe), 32'h0, "good in range");
    @(posedge clk_sys);
    feedback_low <= 1'b1;
    settle();
    chk(32'({power_good_oe, inrush_gate_on}), 32'h3, "feedback low");
    rd(OFS_STATUS, 32'h0, "status not good");
    @(posedge clk_sys);
    feedback_low <= 1'b0;
    supply_ok <= 1'b0;
    settle();
    chk(32'(power_good_oe), 32'h1, "supply bad");
    @(posedge clk_sys);
    supply_ok <= 1'b1;
    settle();
  endtask : t_power_good

  // Lockouts stop the load gate only; the sticky flag raises the alert
  task automatic t_lockout;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      undervoltage_lockout <= !k[0];
      overvoltage_lockout <= k[0];
      settle();
      gates(2'b01, "lockout");
      @(posedge clk_sys);
      undervoltage_lockout <= 1'b0;
      overvoltage_lockout <= 1'b0;
      settle();
      chk(32'(alert_n_oe), 32'h1, "alert raised");
      rd(OFS_STATUS, 32'h8 | (32'h2 << k), "sticky lockout");
      wr(OFS_STATUS, 32'h7);
      rd(OFS_STATUS, 32'h8, "sticky cleared");
      chk(32'(alert_n_oe), 32'h0, "alert cleared");
    end
  endtask : t_lockout

  // Trip on the charge tick that reaches the timeout: 60 on the 3rd, 0x400 on the 52nd;
  // the pin lags by four cycles and the current runs five ticks past the trip
  task automatic t_overcurrent;
    int n;
    int nexp;
    for (int k = 0; k < 2; k++) begin
      nexp = k ? 52 : 3;
      @(posedge clk_sys);
      fault_cap_fitted <= (k == 0);
      current_monitor <= 1'b1;
      wfault(1'b1, nexp + 10, n);
      chk(32'(n >= nexp && n <= nexp + 5), 32'h1, "trip time");
      @(posedge clk_sys);
      current_monitor <= 1'b0;
      settle();
      gates(2'b00, "gates off on trip");
      wfault(1'b0, 20 * (nexp + 6), n);
      chk(32'(n >= 20 * (nexp + 4)), 32'h1, "discharge too fast");
      rd(OFS_STATUS, 32'h9, "trip sticky");
      wr(OFS_STATUS, 32'h1);
      settle();
      gates(2'b11, "gates back");
    end
  endtask : t_overcurrent

  task automatic t_telemetry;
    rd(OFS_VIN, 32'h155, "input reading");
    rd(OFS_VOUT, 32'h2aa, "load reading");
    rd(8'h3c, 32'h0, "unmapped");
    bus(1'b0);
    rd(OFS_VIN, 32'h0, "reading with bus off");
    bus(1'b1);
  endtask : t_telemetry

  // Strap 0x046 encodes digits 2,1,0,1,0, value 32 with good parity
  task automatic t_serial;
    rd(OFS_ADDRESS, 32'h20, "strapped address");
    rd(OFS_STATUS, 32'h8, "no default flag");
    host.send_addr(8'h40, ack);
    chk(32'(ack), 32'h1, "own address");
    host.send_addr(8'hc2, ack);
    chk(32'(ack), 32'h0, "other address");
    bus(1'b0);
    host.send_addr(8'h40, ack);
    chk(32'(ack), 32'h0, "link with bus off");
    bus(1'b1);
  endtask : t_serial

  // Master reset clears flags, restores ON and retakes the address
  task automatic t_mreset;
    @(posedge clk_sys);
    undervoltage_lockout <= 1'b1;
    address_parity <= 1'b1;
    settle();
    @(posedge clk_sys);
    undervoltage_lockout <= 1'b0;
    wr(OFS_OPERATION, 32'h0);
    @(posedge clk_sys);
    master_reset_n <= 1'b0;
    settle();
    chk(32'({gate_strong_off, inrush_gate_on, or_gate_on}), 32'h4, "master reset");
    @(posedge clk_sys);
    master_reset_n <= 1'b1;
    settle();
    chk(32'({gate_strong_off, inrush_gate_on, or_gate_on}), 32'h3, "after reset");
    rd(OFS_OPERATION, 32'h80, "ON restored");
    rd(OFS_STATUS, 32'h18, "flags cleared, default");
    rd(OFS_ADDRESS, 32'h61, "default address");
    host.send_addr(8'hc3, ack);
    chk(32'(ack), 32'h1, "default address acked");
  endtask : t_mreset

  // Main sequence: pins start in the enabled state
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    {inrush_gate_enable, or_gate_enable, master_reset_n, sleep_n, mgmt_bus_enable} = 5'h1f;
    {master_enable_n, undervoltage_lockout, overvoltage_lockout, feedback_low} = 4'h0;
    {current_monitor, address_parity, reg_write, reg_read} = 4'h0;
    {supply_ok, fault_cap_fitted} = 2'b11;
    fault_cap_timeout = 12'd60;
    timer_cap_div = 8'h01;
    adc_vin = 10'h155;
    adc_vout = 10'h2aa;
    address_strap = 10'h046;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    chk(32'({gate_strong_off, inrush_gate_on, or_gate_on}), 32'h4, "in reset");
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    settle();
    gates(2'b11, "enabled from reset");
    rd(OFS_OPERATION, 32'h80, "operation reset");
    t_enables();
    t_bus_off();
    t_pulse();
    t_sleep();
    t_power_good();
    t_lockout();
    t_overcurrent();
    t_telemetry();
    t_serial();
    t_mreset();
    conclude();
  end

  // Watchdog against a hang
  initial begin
    #1500us;
    failures++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    conclude();
  end
endmodule : tb_power_switch_ctrl
